// *** rgp_pkg.sv ***
// package of constants and types shared by both ends of the link
`default_nettype none
package rgp_pkg;
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int FIFO_DEPTH = 8;
  // link clock divider: 40 MHz / (2*LINK_HALF) gives the link clock
  localparam int LINK_HALF = 2;
  localparam logic [1:0] LINK_HALF_M1 = 2'h1;
  // aux clock divider half period minus one, in system cycles
  localparam logic [1:0] AUX_HALF_M1 = 2'h1;
  // link speed codes
  typedef enum logic [1:0] {
    RGP_SPD_10 = 2'h0,
    RGP_SPD_100 = 2'h1,
    RGP_SPD_1000 = 2'h2
  } rgp_speed_t;
  // transmit clock rates per speed, in kHz
  localparam int TXCLK_10_KHZ = 2500;
  localparam int TXCLK_100_KHZ = 25000;
  localparam int TXCLK_1000_KHZ = 125000;
  // power states of the device end
  typedef enum logic [1:0] {
    RGP_PWR_DOWN = 2'h0,
    RGP_PWR_UP = 2'h1
  } rgp_power_t;
  // strap reset value: floating strap reads high
  localparam logic OSC_STRAP_DEFAULT = 1'b1;
  // index of the config strap bit enabling the aux clock
  localparam int CFG_AUXCLK_BIT = 0;
  localparam logic [3:0] CFG_STRAP_RESET = 4'h0;
endpackage
`default_nettype wire

// *** rgp_link_if.sv ***
// interface carrying the reduced gigabit link between both ends
`default_nettype none
interface rgp_link_if;
  import rgp_pkg::*;
  logic rx_clk;
  logic [NIB_W-1:0] rxd;
  logic rx_ctl;
  logic tx_clk;
  logic [NIB_W-1:0] txd;
  logic tx_ctl;
  modport phy (
    output rx_clk, rxd, rx_ctl,
    input tx_clk, txd, tx_ctl
  );
  modport mac (
    input rx_clk, rxd, rx_ctl,
    output tx_clk, txd, tx_ctl
  );
endinterface
`default_nettype wire

// *** rgp_fifo.sv ***
// synchronous valid/ready fifo with parameter width and depth
`default_nettype none
module rgp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // handshakes against registered flags
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rd_ptr];

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH)); // full flag from a flop
      out_valid <= (next_count != '0);
    end
  end
endmodule
`default_nettype wire

// *** rgp_mac_end.sv ***
// mac end: drives transmit nibbles, captures receive nibbles
`default_nettype none
module rgp_mac_end
  import rgp_pkg::*;
#(
  parameter int FDEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // link
  rgp_link_if.mac link,
  // user transmit byte stream
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic tx_err,
  // user receive byte stream
  output logic rx_valid,
  output logic [DATA_W-1:0] rx_data,
  output logic rx_err
);
  logic [1:0] div;
  logic tclk;
  logic [NIB_W-1:0] txd_q;
  logic txctl_q;
  logic fo_valid;
  logic fo_ready;
  logic [DATA_W:0] fo_data;
  logic [NIB_W-1:0] tx_hi_q;
  logic tx_err_q;
  logic [2:0] rclk_s;
  logic [NIB_W-1:0] rxd_s1, rxd_s2;
  logic rctl_s1, rctl_s2;
  logic [NIB_W-1:0] lo_nib;
  logic dv_q;

  // outgoing bytes buffered before the link
  rgp_fifo #(.WIDTH(DATA_W+1), .DEPTH(FDEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data({tx_err, tx_data}),
    .out_valid(fo_valid),
    .out_ready(fo_ready),
    .out_data(fo_data)
  );

  // transmit clock divider, one byte per link period
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div <= '0;
      tclk <= 1'b0;
    end else if (div == LINK_HALF_M1) begin
      div <= '0;
      tclk <= ~tclk; // see R6
    end else begin
      div <= div + 2'h1;
    end
  end
  // take a byte just before the rising edge
  assign fo_ready = (div == LINK_HALF_M1) && !tclk;

  // nibble launch; high half kept since the fifo moves on at pop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txd_q <= '0;
      txctl_q <= 1'b0;
      tx_hi_q <= '0;
      tx_err_q <= 1'b0;
      link.tx_clk <= 1'b0;
    end else begin
      link.tx_clk <= tclk;
      if (fo_ready) begin
        txd_q <= fo_valid ? fo_data[NIB_W-1:0] : '0; // see R5
        txctl_q <= fo_valid; // see R7
        tx_hi_q <= fo_valid ? fo_data[DATA_W-1:NIB_W] : '0;
        tx_err_q <= fo_valid && fo_data[DATA_W];
      end else if (div == LINK_HALF_M1 && tclk) begin
        txd_q <= tx_hi_q; // see R5
        txctl_q <= txctl_q ^ tx_err_q; // see R8 R17
      end
    end
  end
  assign link.txd = txd_q;
  assign link.tx_ctl = txctl_q;

  // receive pins pass two flops before use
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rclk_s <= '0;
      rxd_s1 <= '0;
      rxd_s2 <= '0;
      rctl_s1 <= 1'b0;
      rctl_s2 <= 1'b0;
    end else begin
      rclk_s <= {rclk_s[1:0], link.rx_clk};
      rxd_s1 <= link.rxd;
      rxd_s2 <= rxd_s1;
      rctl_s1 <= link.rx_ctl;
      rctl_s2 <= rctl_s1;
    end
  end

  // receive capture at synchronised edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_nib <= '0;
      dv_q <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= '0;
      rx_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (rclk_s[1] && !rclk_s[2]) begin
        lo_nib <= rxd_s2; // see R1
        dv_q <= rctl_s2; // see R3
      end else if (!rclk_s[1] && rclk_s[2]) begin
        rx_valid <= dv_q;
        rx_data <= {rxd_s2, lo_nib};
        rx_err <= dv_q && (dv_q ^ rctl_s2); // see R4 R17
      end
    end
  end
endmodule
`default_nettype wire

// *** rgp_phy_end.sv ***
// phy end: launches receive nibbles, captures transmit nibbles
// What this block does
// R1 - low rx nibble rising, high falling
// R2 - rx clock from recovered clock, data on rise
// R3 - rx control at rise is data valid
// R4 - rx control at fall encodes error
// R5 - tx nibbles captured rise low, fall high
// R6 - mac supplies a fixed 10 MHz tx clock, 40 MHz / (2*LINK_HALF)
// R7 - tx control at rise is enable
// R8 - tx control at fall encodes error
// R9 - soft reset low powers device down
// R10 - sticky state survives soft reset
// R11 - oscillator strap latched at hard reset release
// R12 - strap pin becomes clock output afterwards
// R13 - config strap enables clock output
// R14 - clock output idle during hard reset
// R15 - disabled clock output held low
// R16 - hard reset powers down, resets all state but the strap synchroniser and the fifo storage
// R17 - falling edge value is flag xor error
`default_nettype none
module rgp_phy_end
  import rgp_pkg::*;
#(
  parameter int FDEPTH = FIFO_DEPTH
) (
  // clock and hard reset
  input wire logic clk,
  input wire logic arst_n,
  // link
  rgp_link_if.phy link,
  // media side receive bytes toward the mac
  input wire logic media_valid,
  output logic media_ready,
  input wire logic [DATA_W-1:0] media_data,
  input wire logic media_err,
  // media side transmit bytes from the mac
  output logic tx_valid,
  output logic [DATA_W-1:0] tx_data,
  output logic tx_err,
  // resets, straps and auxiliary clock pin
  input wire logic soft_reset_n,
  input wire logic [3:0] config_strap_pins,
  input wire logic osc_strap_in,
  output logic osc_strap_out,
  output logic osc_strap_oe_n,
  output logic oscillator_enable_strap,
  output logic powered_up,
  output logic sticky_frame_seen
);
  typedef enum logic [1:0] {
    ST_STRAP = 2'h0,
    ST_AUX_CLOCK_OUTPUT = 2'h1
  } rgp_pin_t;

  logic sr_s1, sr_s2;
  logic os_s1, os_s2;
  logic [3:0] cfg_s1, cfg_s2;
  rgp_pin_t pin_st;
  logic [1:0] rdiv;
  logic rclk;
  logic fo_valid;
  logic fo_ready;
  logic [DATA_W:0] fo_data;
  logic [NIB_W-1:0] rxd_q;
  logic rxctl_q;
  logic rx_err_q;
  logic [NIB_W-1:0] rx_hi_q;
  logic [2:0] tclk_s;
  logic [NIB_W-1:0] txd_s1, txd_s2;
  logic tctl_s1, tctl_s2;
  logic [NIB_W-1:0] lo_nib;
  logic en_q;
  logic [1:0] adiv;
  logic aux;

  // pins from outside pass two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sr_s1 <= 1'b0;
      sr_s2 <= 1'b0;
      cfg_s1 <= CFG_STRAP_RESET;
      cfg_s2 <= CFG_STRAP_RESET;
    end else begin
      sr_s1 <= soft_reset_n;
      sr_s2 <= sr_s1;
      cfg_s1 <= config_strap_pins;
      cfg_s2 <= cfg_s1;
    end
  end

  // strap synchroniser runs through hard reset, pin value ready at release
  always_ff @(posedge clk) begin
    os_s1 <= osc_strap_in;
    os_s2 <= os_s1;
  end

  // power state follows soft reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      powered_up <= 1'b0; // see R16
    end else begin
      powered_up <= sr_s2; // see R9
    end
  end

  // strap capture after hard reset release, then pin turns
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_st <= ST_STRAP;
      oscillator_enable_strap <= OSC_STRAP_DEFAULT;
    end else begin
      unique case (pin_st)
        ST_STRAP: begin
          oscillator_enable_strap <= os_s2; // see R11
          pin_st <= ST_AUX_CLOCK_OUTPUT; // see R12
        end
        ST_AUX_CLOCK_OUTPUT: begin
          pin_st <= ST_AUX_CLOCK_OUTPUT;
        end
        default: begin
          pin_st <= ST_STRAP;
        end
      endcase
    end
  end

  // sticky status kept through soft reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sticky_frame_seen <= 1'b0; // see R16
    end else if (tx_valid) begin
      sticky_frame_seen <= 1'b1; // see R10
    end
  end

  // auxiliary clock output and its enable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adiv <= '0;
      aux <= 1'b0;
      osc_strap_out <= 1'b0; // see R14
      osc_strap_oe_n <= 1'b1;
    end else begin
      adiv <= (adiv == AUX_HALF_M1) ? '0 : adiv + 2'h1;
      if (adiv == AUX_HALF_M1) begin
        aux <= ~aux;
      end
      osc_strap_oe_n <= (pin_st != ST_AUX_CLOCK_OUTPUT); // see R12
      if (pin_st == ST_AUX_CLOCK_OUTPUT && cfg_s2[CFG_AUXCLK_BIT]) begin
        osc_strap_out <= aux; // see R13
      end else begin
        osc_strap_out <= 1'b0; // see R15
      end
    end
  end

  // receive bytes buffered before the link
  rgp_fifo #(.WIDTH(DATA_W+1), .DEPTH(FDEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(media_valid),
    .in_ready(media_ready),
    .in_data({media_err, media_data}),
    .out_valid(fo_valid),
    .out_ready(fo_ready),
    .out_data(fo_data)
  );

  // recovered receive clock, stopped while powered down
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdiv <= '0;
      rclk <= 1'b0;
    end else if (!powered_up && !rclk) begin
      rdiv <= '0; // parks as soon as rclk is low, a high half runs to its end
      rclk <= 1'b0; // see R9
    end else if (rdiv == LINK_HALF_M1) begin
      rdiv <= '0;
      rclk <= ~rclk; // see R2
    end else begin
      rdiv <= rdiv + 2'h1;
    end
  end
  assign fo_ready = powered_up && (rdiv == LINK_HALF_M1) && !rclk;

  // receive nibble launch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxd_q <= '0;
      rxctl_q <= 1'b0;
      rx_err_q <= 1'b0;
      rx_hi_q <= '0;
      link.rx_clk <= 1'b0;
    end else begin
      link.rx_clk <= rclk; // see R2
      if (fo_ready) begin
        rxd_q <= fo_valid ? fo_data[NIB_W-1:0] : '0; // see R1
        rxctl_q <= fo_valid; // see R3
        rx_err_q <= fo_valid && fo_data[DATA_W];
        rx_hi_q <= fo_valid ? fo_data[DATA_W-1:NIB_W] : '0;
      end else if (rdiv == LINK_HALF_M1 && rclk) begin
        rxd_q <= rx_hi_q; // see R1
        rxctl_q <= rxctl_q ^ rx_err_q; // see R4 R17
      end
    end
  end
  assign link.rxd = rxd_q;
  assign link.rx_ctl = rxctl_q;

  // transmit pins pass two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tclk_s <= '0;
      txd_s1 <= '0;
      txd_s2 <= '0;
      tctl_s1 <= 1'b0;
      tctl_s2 <= 1'b0;
    end else begin
      tclk_s <= {tclk_s[1:0], link.tx_clk}; // see R6
      txd_s1 <= link.txd;
      txd_s2 <= txd_s1;
      tctl_s1 <= link.tx_ctl;
      tctl_s2 <= tctl_s1;
    end
  end

  // transmit capture at synchronised edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_nib <= '0;
      en_q <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= '0;
      tx_err <= 1'b0;
    end else begin
      tx_valid <= 1'b0;
      if (tclk_s[1] && !tclk_s[2]) begin
        lo_nib <= txd_s2; // see R5
        en_q <= tctl_s2; // see R7
      end else if (!tclk_s[1] && tclk_s[2]) begin
        tx_valid <= en_q && powered_up;
        tx_data <= {txd_s2, lo_nib}; // see R5
        tx_err <= en_q && (en_q ^ tctl_s2); // see R8 R17
      end
    end
  end
endmodule
`default_nettype wire

// *** rgp_link_checker.sv ***
// checker of timing relations on the reduced gigabit link
`default_nettype none
module rgp_link_checker
  import rgp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // receive direction
  input wire logic rx_clk,
  input wire logic [NIB_W-1:0] rxd,
  input wire logic rx_ctl,
  // transmit direction
  input wire logic tx_clk,
  input wire logic [NIB_W-1:0] txd,
  input wire logic tx_ctl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // link clocks hold each level at least two cycles
  rx_clk_half_a: assert property (
    $changed(rx_clk) |=> $stable(rx_clk)) else $error("rx clock short");
  tx_clk_half_a: assert property (
    $changed(tx_clk) |=> $stable(tx_clk)) else $error("tx clock short");
  // nibbles stand two cycles
  rx_nib_hold_a: assert property (
    $changed(rxd) |=> $stable(rxd)) else $error("rx nibble short");
  tx_nib_hold_a: assert property (
    $changed(txd) |=> $stable(txd)) else $error("tx nibble short");
  // idle link carries zero nibbles
  rx_idle_zero_a: assert property (
    $rose(rx_clk) && !rx_ctl |-> rxd == 4'h0) else $error("rx idle data");
  tx_idle_zero_a: assert property (
    $rose(tx_clk) && !tx_ctl |-> txd == 4'h0) else $error("tx idle data");
  // no error flagged outside valid bytes
  rx_idle_err_a: assert property (
    $rose(rx_clk) && !rx_ctl |-> ##2 !rx_ctl) else $error("rx idle error");
  tx_idle_err_a: assert property (
    $rose(tx_clk) && !tx_ctl |-> ##2 !tx_ctl) else $error("tx idle error");
  // main traffic cases
  cover property ($rose(rx_clk) && rx_ctl);
  cover property ($rose(tx_clk) && tx_ctl);
  cover property ($rose(rx_clk) && rx_ctl ##2 !rx_ctl);
  cover property ($rose(tx_clk) && tx_ctl ##2 !tx_ctl);
endmodule
`default_nettype wire

// *** tb_rgmii_phy_side_port.sv ***
// bench for both link ends: traffic, buffering, resets and straps
`default_nettype none
module tb_rgmii_phy_side_port
  import rgp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, soft_reset_n, strap_lvl, m_valid, m_ready, m_err;
  logic t_valid, t_ready, t_err, p_valid, p_err, r_valid, r_err;
  logic osc_out, osc_oe_n, osc_en, pwr, sticky;
  logic [7:0] m_data, t_data, p_data, r_data;
  logic [3:0] cfg;
  logic [31:0] lf;
  logic [8:0] uq[2][$];
  logic [8:0] wq[2][$];
  logic pclk[2];
  logic vf[2];
  logic [3:0] lo[2];
  int err_total, n_checks;
  wire logic strap_pin = osc_oe_n ? strap_lvl : osc_out;
  rgp_link_if rgp_link_if_i ();
  rgp_phy_end rgp_phy_end_i (.clk(clk), .arst_n(arst_n),
    .link(rgp_link_if_i.phy), .media_valid(m_valid), .media_ready(m_ready),
    .media_data(m_data), .media_err(m_err), .tx_valid(p_valid),
    .tx_data(p_data), .tx_err(p_err), .soft_reset_n(soft_reset_n),
    .config_strap_pins(cfg), .osc_strap_in(strap_pin),
    .osc_strap_out(osc_out), .osc_strap_oe_n(osc_oe_n),
    .oscillator_enable_strap(osc_en), .powered_up(pwr),
    .sticky_frame_seen(sticky));
  rgp_mac_end rgp_mac_end_i (.clk(clk), .arst_n(arst_n),
    .link(rgp_link_if_i.mac), .tx_valid(t_valid), .tx_ready(t_ready),
    .tx_data(t_data), .tx_err(t_err), .rx_valid(r_valid), .rx_data(r_data),
    .rx_err(r_err));
  rgp_link_checker rgp_link_checker_i (.clk(clk), .arst_n(arst_n),
    .rx_clk(rgp_link_if_i.rx_clk), .rxd(rgp_link_if_i.rxd),
    .rx_ctl(rgp_link_if_i.rx_ctl), .tx_clk(rgp_link_if_i.tx_clk),
    .txd(rgp_link_if_i.txd), .tx_ctl(rgp_link_if_i.tx_ctl));
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // falling edge control value for a byte with error flag
  function automatic logic fall_ctl(input logic [8:0] v);
    return 1'b1 ^ v[8];
  endfunction
  // next expected user byte of one direction, unknown if none is due
  function automatic logic [8:0] pop_exp(input int d);
    return uq[d].size() ? uq[d].pop_front() : 9'bx;
  endfunction
  task automatic chk(input string what, input logic [8:0] exp, seen);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // offer one byte, hold it until the fifo takes it
  task automatic send(input int d, input logic [8:0] v, input logic u);
    int i;
    @(negedge clk);
    if (d == 0) begin
      m_valid = 1'b1;
      {m_err, m_data} = v;
    end else begin
      t_valid = 1'b1;
      {t_err, t_data} = v;
    end
    for (i = 0; i < 400 && (d ? t_ready : m_ready) !== 1'b1; i++) begin
      @(negedge clk);
    end
    if (i == 400) begin
      err_total++;
      complete_run();
    end
    if (u) begin
      uq[d].push_back(v);
    end
    wq[d].push_back(v);
    @(posedge clk);
  endtask
  task automatic idle();
    @(negedge clk);
    m_valid = 1'b0;
    t_valid = 1'b0;
  endtask
  task automatic drain();
    int i;
    for (i = 0; i < 3000 && uq[0].size() + uq[1].size() > 0; i++) begin
      @(negedge clk);
    end
    if (i == 3000) begin
      err_total++;
      complete_run();
    end
    repeat (20) @(negedge clk);
  endtask
  // count aux clock transitions over sixteen cycles
  task automatic aux(input logic [8:0] exp);
    logic [8:0] n;
    logic p;
    n = 9'h0;
    p = osc_out;
    repeat (16) begin
      @(negedge clk);
      n += 9'(osc_out !== p);
      p = osc_out;
    end
    chk("aux edges", exp, n);
  endtask
  // wire level view of one direction
  task automatic mon(input int d, input logic c, k, input logic [3:0] n);
    logic [8:0] e;
    if (c === 1'b1 && pclk[d] === 1'b0) begin
      lo[d] = n;
      vf[d] = k;
    end
    if (c === 1'b0 && pclk[d] === 1'b1 && vf[d] === 1'b1) begin
      e = wq[d].size() ? wq[d].pop_front() : 9'bx;
      chk("wire", {fall_ctl(e), e[7:0]}, {k, n, lo[d]});
    end
    pclk[d] = c;
  endtask
  // observe link and both user outputs where settled
  always @(negedge clk) begin
    mon(0, rgp_link_if_i.rx_clk, rgp_link_if_i.rx_ctl, rgp_link_if_i.rxd);
    mon(1, rgp_link_if_i.tx_clk, rgp_link_if_i.tx_ctl, rgp_link_if_i.txd);
    if (r_valid === 1'b1) begin
      chk("mac rx", pop_exp(0), {r_err, r_data});
    end
    if (p_valid === 1'b1) begin
      chk("phy tx", pop_exp(1), {p_err, p_data});
    end
  end
  // main sequence
  initial begin
    clk = 1'h0;
    arst_n = 1'h0;
    soft_reset_n = 1'h0;
    strap_lvl = 1'h0;
    cfg = 4'h1;
    m_valid = 1'h0;
    m_err = 1'h0;
    m_data = 8'h0;
    t_valid = 1'h0;
    t_err = 1'h0;
    t_data = 8'h0;
    lf = 32'h43cc;
    err_total = 0;
    n_checks = 0;
    repeat (2) @(negedge clk);
    chk("reset pins", 9'h2, {osc_oe_n, osc_out});
    chk("reset state", 9'h4, {osc_en, pwr, sticky});
    arst_n = 1;
    repeat (4) @(negedge clk);
    chk("strap", 9'h0, {osc_en, osc_oe_n});
    aux(9'h8);
    for (int i = 0; i < 8; i++) begin
      send(0, {1'b0, 8'(i * 37)}, 1'b1);
    end
    idle();
    chk("full ready", 9'h0, {m_ready, pwr});
    send(1, 9'h05a, 1'b0);
    idle();
    repeat (40) @(negedge clk);
    soft_reset_n = 1;
    drain();
    chk("powered", 9'h1, pwr);
    for (int j = 0; j < 4; j++) begin
      send(j % 2, 9'h0ff, 1'b1);
      send(j % 2, 9'h100, 1'b1);
      for (int i = 0; i < 10; i++) begin
        send(j % 2, {lf[7:5] == 3'h0, lf[15:8]}, 1'b1);
        lf = lfsr_next(lf);
      end
      idle();
    end
    drain();
    soft_reset_n = 0;
    repeat (8) @(negedge clk);
    chk("sticky", 9'h2, {sticky, pwr});
    soft_reset_n = 1;
    arst_n = 0;
    cfg = 4'h0;
    strap_lvl = 1;
    repeat (2) @(negedge clk);
    chk("hard reset", 9'h0, {sticky, pwr});
    arst_n = 1;
    repeat (4) @(negedge clk);
    chk("strap high", 9'h1, osc_en);
    aux(9'h0);
    chk("aux low", 9'h0, osc_out);
    complete_run();
  end
endmodule
`default_nettype wire
